// >>> include/phy_strap_map.vh
// reset window, strap and power-mode constants for the strap/reset/power control block
`ifndef PHY_STRAP_MAP_VH
`define PHY_STRAP_MAP_VH

// ==========================================================================
// timing
// ==========================================================================
`define RESET_STRETCH_US      258
`define CORE_CLK_MHZ          100
`define RESET_STRETCH_CYCLES  (`RESET_STRETCH_US * `CORE_CLK_MHZ)

// ==========================================================================
// field positions of the shadowed control bits
// ==========================================================================
`define CTRL_SW_RESET_BIT     15
`define CTRL_LOOPBACK_BIT     14
`define CFG_SLEEP_BIT         6
`define CFG_FIBER_BIT         0

// ==========================================================================
// address width and reset value
// ==========================================================================
`define ADDR_WIDTH            5
`define ADDR_RESET            5'h00

`endif

// >>> hw/sync_2ff.v
// two flip-flop synchroniser for a bus of independent levels
`timescale 1ns/100ps

module sync_2ff #(
    parameter WIDTH = 1
) (
    // clock and reset
    input  wire             i_core_clk,
    input  wire             i_resetn,
    // data
    input  wire [WIDTH-1:0] i_async,
    output wire [WIDTH-1:0] o_sync
);

    reg [WIDTH-1:0] meta_ff;
    reg [WIDTH-1:0] sync_ff;

    // the first stage is read only by the second stage
    always @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            meta_ff <= {WIDTH{1'b0}};
            sync_ff <= {WIDTH{1'b0}};
        end else begin
            meta_ff <= i_async;
            sync_ff <= meta_ff;
        end
    end

    assign o_sync = sync_ff;

endmodule // sync_2ff

// >>> hw/phy_strap_reset_power_control.v
// reset stretching, strap capture and power-mode control for a 10/100 transceiver
// ==========================================================================
// ==========================================================================
`timescale 1ns/100ps
`include "phy_strap_map.vh"

module phy_strap_reset_power_control #(
    parameter STRETCH_CYCLES = `RESET_STRETCH_CYCLES,
    parameter ADDR_W         = `ADDR_WIDTH
) (
    // clock and reset
    input  wire              i_core_clk,
    input  wire              i_resetn,
    // board pins, asynchronous to the core clock
    input  wire              i_pin_resetn,
    input  wire              i_media_select_detect_pin,
    input  wire [ADDR_W-1:0] i_addr_strap,
    input  wire              i_pause_pin,
    input  wire              i_sleep_pin,
    input  wire              i_power_down_pin,
    input  wire              i_mgmt_disable_pin,
    // management side, same clock domain
    input  wire              i_sw_reset_set,
    input  wire              i_sleep_reg_wr,
    input  wire              i_sleep_reg_val,
    input  wire              i_fiber_reg_wr,
    input  wire              i_fiber_reg_val,
    input  wire              i_loopback_reg_val,
    // status and control outputs
    output reg               o_core_reset,
    output reg               o_sw_reset_bit,
    output reg               o_fiber_media_mode,
    output reg               o_copper_media_mode,
    output reg               o_fiber_signal_detect,
    output reg  [ADDR_W-1:0] o_mgmt_addr,
    output reg               o_pause_advertise,
    output reg               o_sleep_mode,
    output reg               o_power_down_mode,
    output reg               o_managed_mode,
    output reg               o_sleep_reg_bit,
    output reg               o_loopback_active
);

    // ======================================================================
    // pin synchronisation
    // ======================================================================
    localparam SW = ADDR_W + 6;
    wire [SW-1:0] pins_sync;

    sync_2ff #(
        .WIDTH (SW)
    ) u_pin_sync (
        .i_core_clk (i_core_clk),
        .i_resetn   (i_resetn),
        .i_async    ({i_pin_resetn, i_media_select_detect_pin, i_addr_strap,
                      i_pause_pin, i_sleep_pin, i_power_down_pin,
                      i_mgmt_disable_pin}),
        .o_sync     (pins_sync)
    );

    // the synchroniser resets to zero, so reset pin reads as asserted until seen high
    wire              pin_resetn_s = pins_sync[SW-1];
    wire              media_pin_s  = pins_sync[SW-2];
    wire [ADDR_W-1:0] addr_s       = pins_sync[SW-3 -: ADDR_W];
    wire              pause_s      = pins_sync[3];
    wire              sleep_pin_s  = pins_sync[2];
    wire              pwrdn_s      = pins_sync[1];
    wire              mgmt_dis_s   = pins_sync[0];

    // ======================================================================
    // reset request and stretch
    // ======================================================================
    localparam CW = 32;
    localparam [CW-1:0] STRETCH_LAST = STRETCH_CYCLES - 1;

    reg  [CW-1:0] stretch_cnt_ff;
    reg  [CW-1:0] nxt_stretch_cnt;
    reg           in_reset_ff;
    reg           sw_reset_ff;

    wire reset_req = ~pin_resetn_s | sw_reset_ff;
    wire stretch_done = in_reset_ff & ~reset_req & (stretch_cnt_ff == STRETCH_LAST);

    always @* begin
        if (reset_req)
            nxt_stretch_cnt = {CW{1'b0}};
        else if (in_reset_ff && !stretch_done)
            nxt_stretch_cnt = stretch_cnt_ff + 32'h0000_0001;
        else
            nxt_stretch_cnt = stretch_cnt_ff;
    end

    always @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            stretch_cnt_ff <= {CW{1'b0}};
            in_reset_ff    <= 1'b1;
            sw_reset_ff    <= 1'b0;
        end else begin
            stretch_cnt_ff <= nxt_stretch_cnt;
            if (reset_req)
                in_reset_ff <= 1'b1;
            else if (stretch_done)
                in_reset_ff <= 1'b0;
            // writes are taken only outside the window; the bit clears in the window's first cycle
            if (i_sw_reset_set && !in_reset_ff)
                sw_reset_ff <= 1'b1;
            else if (sw_reset_ff && in_reset_ff && stretch_cnt_ff == {CW{1'b0}})
                sw_reset_ff <= 1'b0;               // request consumed, window restarts
        end
    end

    // ======================================================================
    // strap capture and control shadows
    // ======================================================================
    reg              fiber_ff;
    reg [ADDR_W-1:0] addr_ff;
    reg              pause_ff;
    reg              managed_ff;
    reg              sleep_bit_ff;

    always @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            fiber_ff     <= 1'b0;
            addr_ff      <= `ADDR_RESET;
            pause_ff     <= 1'b0;
            managed_ff   <= 1'b0;
            sleep_bit_ff <= 1'b0;
        end else if (stretch_done) begin
            fiber_ff     <= media_pin_s;
            addr_ff      <= addr_s;
            pause_ff     <= pause_s;
            managed_ff   <= ~mgmt_dis_s;
            sleep_bit_ff <= sleep_pin_s;           // default from pin
        end else if (!in_reset_ff && managed_ff) begin
            if (i_fiber_reg_wr)
                fiber_ff <= i_fiber_reg_val;
            if (i_sleep_reg_wr)
                sleep_bit_ff <= i_sleep_reg_val;
        end
    end

    // ======================================================================
    // outputs, all registered
    // ======================================================================
    always @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_core_reset          <= 1'b1;
            o_sw_reset_bit        <= 1'b0;
            o_fiber_media_mode    <= 1'b0;
            o_copper_media_mode   <= 1'b1;
            o_fiber_signal_detect <= 1'b0;
            o_mgmt_addr           <= `ADDR_RESET;
            o_pause_advertise     <= 1'b0;
            o_sleep_mode          <= 1'b0;
            o_power_down_mode     <= 1'b0;
            o_managed_mode        <= 1'b0;
            o_sleep_reg_bit       <= 1'b0;
            o_loopback_active     <= 1'b0;
        end else begin
            o_core_reset          <= in_reset_ff | reset_req;
            o_sw_reset_bit        <= sw_reset_ff | (i_sw_reset_set & ~in_reset_ff)
                                     | (o_sw_reset_bit & in_reset_ff);
            o_fiber_media_mode    <= fiber_ff;
            o_copper_media_mode   <= ~fiber_ff;
            // signal detect only has meaning outside reset and in fiber mode
            o_fiber_signal_detect <= fiber_ff & ~in_reset_ff & media_pin_s;
            o_mgmt_addr           <= addr_ff;
            o_pause_advertise     <= pause_ff & ~in_reset_ff;
            o_sleep_mode          <= ~in_reset_ff &
                                     (managed_ff ? sleep_bit_ff : sleep_pin_s);
            o_power_down_mode     <= pwrdn_s;
            o_managed_mode        <= managed_ff;
            o_sleep_reg_bit       <= sleep_bit_ff;
            // loopback in fiber mode needs the far side to hold detect high
            o_loopback_active     <= i_loopback_reg_val & ~in_reset_ff &
                                     (~fiber_ff | media_pin_s);
        end
    end

endmodule // phy_strap_reset_power_control

// >>> dv/board_strap_model.sv
// board strap and fiber optic model that drives the dual-use media pin
`timescale 1ns/100ps
module board_strap_model (
    input  wire i_core_reset,
    input  wire i_fiber_strap,
    input  wire i_optic_detect,
    output wire o_media_select_detect_pin
);
    // strap level while the window runs, then the optic's detect; copper boards tie it low
    assign o_media_select_detect_pin = i_core_reset ? i_fiber_strap
                                     : (i_fiber_strap & i_optic_detect);
endmodule // board_strap_model

// >>> dv/strap_ctrl_props.sv
// concurrent checks on the strap, reset and power-mode control ports
`timescale 1ns/100ps
module strap_ctrl_props #(parameter STRETCH_CYCLES = 20) (
    input wire i_core_clk, i_resetn, i_pin_resetn, i_power_down_pin,
    input wire o_core_reset, o_sw_reset_bit, o_fiber_media_mode, o_copper_media_mode,
    input wire o_fiber_signal_detect, o_pause_advertise, o_sleep_mode,
    input wire o_power_down_mode, o_managed_mode, o_sleep_reg_bit,
    input wire [4:0] o_mgmt_addr
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_resetn);
    // ==========================================================================
    // window counter: cycles held in reset with the pin released
    integer win_ff;
    always @(posedge i_core_clk or negedge i_resetn)
        if (!i_resetn) win_ff <= 0;
        else win_ff <= (o_core_reset && i_pin_resetn) ? win_ff + 1 : 0;
    win_len_a:
    assert property ($fell(o_core_reset) |-> win_ff >= STRETCH_CYCLES - 1
        && win_ff <= STRETCH_CYCLES + 6) else $error("reset window length off");
    pin_rst_a:
    assert property (!i_pin_resetn [*4] |-> o_core_reset) else $error("pin reset lost");
    sw_rst_a:
    assert property ($rose(o_sw_reset_bit) |=> o_core_reset) else $error("sw reset lost");
    sw_clr_a:
    assert property ($fell(o_sw_reset_bit) |-> $fell(o_core_reset)) else $error("sw bit clear");
    media_pair_a:
    assert property (o_copper_media_mode != o_fiber_media_mode) else $error("media pair");
    detect_gate_a:
    assert property ((o_core_reset || o_copper_media_mode) [*2] |-> !o_fiber_signal_detect)
        else $error("detect not gated");
    strap_hold_a:
    assert property (!o_core_reset && !$past(o_core_reset) |-> $stable(o_mgmt_addr)
        && $stable(o_pause_advertise)) else $error("straps moved");
    pdown_hold_a:
    assert property ((i_power_down_pin && !o_core_reset) [*4] |-> o_power_down_mode)
        else $error("power down missed");
    sleep_reg_a:
    assert property ((o_managed_mode && !o_core_reset && o_sleep_reg_bit) [*3]
        |-> o_sleep_mode) else $error("sleep override");
    cover property ($fell(o_core_reset));
    cover property ($rose(o_sw_reset_bit));
    cover property (o_fiber_signal_detect && o_managed_mode);
endmodule // strap_ctrl_props
bind phy_strap_reset_power_control strap_ctrl_props #(.STRETCH_CYCLES(STRETCH_CYCLES)) props (
    .i_core_clk, .i_resetn, .i_pin_resetn, .i_power_down_pin, .o_core_reset,
    .o_sw_reset_bit, .o_fiber_media_mode, .o_copper_media_mode, .o_fiber_signal_detect,
    .o_pause_advertise, .o_sleep_mode, .o_power_down_mode, .o_managed_mode,
    .o_sleep_reg_bit, .o_mgmt_addr);

// >>> dv/phy_strap_reset_power_control_tb.sv
// self-checking bench for the strap, reset and power-mode control block
`timescale 1ns/100ps
module phy_strap_reset_power_control_tb;
    localparam STRETCH = 20;
    reg clk = 1'b0, rstn = 1'b0, prst = 1'b1, fstr = 1'b0, det = 1'b0, pause = 1'b1;
    reg slp = 1'b0, pdn = 1'b0, mdis = 1'b1, swr = 1'b0, s_wr = 1'b0, s_val = 1'b0;
    reg f_wr = 1'b0, f_val = 1'b0, lpb = 1'b0;
    reg [4:0] addr = 5'h15;
    wire core_rst, swbit, fib, cop, sig_det, pau, slm, pdm, mgd, sbit, lpa, pin;
    wire [4:0] maddr;
    integer n_mismatch = 0, n_checks = 0, cyc = 0, w, i;
    // 100 MHz stands in for the 25 MHz reference the board supplies
    initial forever #5 clk = ~clk;
    board_strap_model far (.i_core_reset(core_rst), .i_fiber_strap(fstr),
        .i_optic_detect(det), .o_media_select_detect_pin(pin));
    phy_strap_reset_power_control #(.STRETCH_CYCLES(STRETCH)) dut (
        .i_core_clk(clk), .i_resetn(rstn), .i_pin_resetn(prst),
        .i_media_select_detect_pin(pin), .i_addr_strap(addr), .i_pause_pin(pause),
        .i_sleep_pin(slp), .i_power_down_pin(pdn), .i_mgmt_disable_pin(mdis),
        .i_sw_reset_set(swr), .i_sleep_reg_wr(s_wr), .i_sleep_reg_val(s_val),
        .i_fiber_reg_wr(f_wr), .i_fiber_reg_val(f_val), .i_loopback_reg_val(lpb),
        .o_core_reset(core_rst), .o_sw_reset_bit(swbit), .o_fiber_media_mode(fib),
        .o_copper_media_mode(cop), .o_fiber_signal_detect(sig_det), .o_mgmt_addr(maddr),
        .o_pause_advertise(pau), .o_sleep_mode(slm), .o_power_down_mode(pdm),
        .o_managed_mode(mgd), .o_sleep_reg_bit(sbit), .o_loopback_active(lpa));
    task chk(input [8*12-1:0] nm, input [4:0] exp, input [4:0] got);
        begin
            n_checks = n_checks + 1;
            if (exp !== got) begin
                n_mismatch = n_mismatch + 1;
                $display("wrong value %0s exp %h got %h", nm, exp, got);
            end
        end
    endtask
    task complete_run;
        begin
            $display("checks %0d mismatches %0d", n_checks, n_mismatch);
            if (n_mismatch == 0 && n_checks > 0) $display("Finished cleanly");
            else $display("Finished with errors");
            $finish;
        end
    endtask
    // bounded wait for the window to close; w keeps the cycles spent
    task wait_up;
        begin
            w = 0;
            while (core_rst !== 1'b0 && w < 200) begin
                @(negedge clk);
                w = w + 1;
            end
            chk("reset done", 5'h00, core_rst);
        end
    endtask
    task pin_reset(input f, input [4:0] a, input p, input md);
        begin
            fstr = f;
            addr = a;
            pause = p;
            mdis = md;
            prst = 1'b0;
            repeat (5) @(negedge clk);
            chk("pin reset", 5'h01, core_rst);
            prst = 1'b1;
            wait_up;
            chk("window", 5'h01, w >= STRETCH + 2 && w <= STRETCH + 6);
        end
    endtask
    // a hang counts as a mismatch
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            n_mismatch = n_mismatch + 1;
            complete_run;
        end
    end
    initial begin
        repeat (20) @(negedge clk);
        rstn = 1'b1;
        wait_up;
        chk("copper", 5'h01, cop);
        chk("addr", 5'h15, maddr);
        chk("pause", 5'h01, pau);
        chk("managed", 5'h00, mgd);
        addr = 5'h0a;
        pause = 1'b0;
        slp = 1'b1;
        pdn = 1'b1;
        f_wr = 1'b1;
        f_val = 1'b1;
        @(negedge clk);
        f_wr = 1'b0;
        repeat (4) @(negedge clk);
        chk("addr held", 5'h15, maddr);
        chk("pause held", 5'h01, pau);
        chk("fiber wr", 5'h00, fib);
        chk("sleep pin", 5'h01, slm);
        chk("pdown", 5'h01, pdm);
        pdn = 1'b0;
        pin_reset(1'b1, 5'h0a, 1'b0, 1'b0);
        chk("fiber", 5'h01, fib);
        chk("addr", 5'h0a, maddr);
        chk("managed", 5'h01, mgd);
        chk("pdown off", 5'h00, pdm);
        det = 1'b1;
        lpb = 1'b1;
        repeat (4) @(negedge clk);
        chk("detect", 5'h01, sig_det);
        chk("loopback", 5'h01, lpa);
        // optic drops detect: both detect and fiber loopback must fall
        det = 1'b0;
        repeat (4) @(negedge clk);
        chk("detect lost", 5'h00, sig_det);
        chk("loop no det", 5'h00, lpa);
        for (i = 0; i < 2; i = i + 1) begin
            s_wr = 1'b1;
            s_val = i[0];
            @(negedge clk);
            s_wr = 1'b0;
            repeat (4) @(negedge clk);
            chk("sleep reg", i[4:0], slm);
            chk("sleep bit", i[4:0], sbit);
        end
        swr = 1'b1;
        @(negedge clk);
        swr = 1'b0;
        @(negedge clk);
        chk("sw bit", 5'h01, swbit);
        @(negedge clk);
        chk("sw core rst", 5'h01, core_rst);
        repeat (8) @(negedge clk);
        // a second request inside the window must not restart it
        swr = 1'b1;
        @(negedge clk);
        swr = 1'b0;
        wait_up;
        chk("sw window", 5'h01, w <= STRETCH - 5);
        chk("sw bit clr", 5'h00, swbit);
        f_wr = 1'b1;
        f_val = 1'b0;
        @(negedge clk);
        f_wr = 1'b0;
        repeat (4) @(negedge clk);
        chk("copper wr", 5'h01, cop);
        pin_reset(1'b0, 5'h1f, 1'b1, 1'b1);
        chk("addr", 5'h1f, maddr);
        complete_run;
    end
endmodule // phy_strap_reset_power_control_tb
